/* flash_program_strobe_device.sv */
// device end: code flash array, lock bits, self-timed write, polling, busy
// assumes pins arrive asynchronously and are synchronised here
//
// Behaviour
// [RULE1] blank array reads FFH everywhere
// [RULE2] accepts high or low voltage enable
// [RULE3] one byte per write cycle
// [RULE4] host sets address, data, mode, voltage
// [RULE5] one strobe per write, self timed
// [RULE6] busy read returns inverted top bit
// [RULE7] true data once write completes
// [RULE8] busy low after strobe rises
// [RULE9] busy within 1 us, write within 2 ms
// [RULE10] verify only with locks one, two clear; the code blocks verify only once locks one and two are both set
// [RULE11] lock bits are never read back
// [RULE12] ten ms erase strobe sets all ones
// [RULE13] mode select codes for each operation
// [RULE14] lock writes use select codes, one strobe
// [RULE15] signature read at 030H to 032H
// [RULE16] signature bytes maker, part, voltage
// [RULE17] lock one blocks table reads, programming
// [RULE18] more locks disable verify, external run
// [RULE19] access level latched at reset
// [RULE20] strobe width and voltage setup limits
// [RULE21] strobes ignored while busy
// [RULE22] address low on port 1, high port 2
`timescale 1ns/1ps
`default_nettype none
module flash_program_strobe_device
  import flash_program_strobe_pkg::*;
#(
  parameter int  WRITE_TIME   = flash_program_strobe_pkg::WRITE_CYCLES,
  parameter int  ERASE_TIME   = flash_program_strobe_pkg::ERASE_STROBE_CYCLES,
  parameter bit  LOW_VOLTAGE  = 1'b0
)(
  input  wire logic clock_i,
  input  wire logic resetn_i,
  flash_program_strobe_if.device link,
  input  wire logic table_read_external_i,
  input  wire logic external_access_pin_i,
  output logic      table_read_allowed_o,
  output logic      external_run_allowed_o,
  output logic      external_access_latched_o
);
  import flash_program_strobe_pkg::*;

  if (WRITE_TIME < 1 || ERASE_TIME < 2) begin : bad_timing
    $error("flash_program_strobe_device: timing parameters too small");
  end

  // address, data, eight control bits and the access pin
  localparam int SYNC_W = ADDR_WIDTH + 17;
  // reset and program strobe pins sit high when idle, so no false edge after reset
  localparam logic [SYNC_W-1:0] SYNC_IDLE = SYNC_W'(9'h140);

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_WRITE = 3'b010,
    ST_LOCK  = 3'b100
  } dev_state_type;

  typedef struct packed {
    dev_state_type          state;
    logic [SYNC_W-1:0]      sync1;
    logic [SYNC_W-1:0]      sync2;
    logic                   strobe_prev;
    logic [31:0]            timer;
    logic [31:0]            erase_count;
    logic [ADDR_WIDTH-1:0]  last_addr;
    logic [7:0]             last_data;
    logic [ADDR_WIDTH-1:0]  pend_addr;
    logic [2:0]             lock;
    logic                   ea_latch;
    logic                   ea_armed;
    logic [7:0]             dout;
    logic                   oe_n;
    logic                   ready;
    logic                   tr_allowed;
    logic                   ext_allowed;
  } dev_reg_type;

  dev_reg_type r;
  dev_reg_type next_r;
  logic [7:0]  mem [MEM_DEPTH];
  logic        mem_we;
  logic        mem_clear;
  logic [7:0]  mem_rd;

  // synchronised pin view
  logic [ADDR_WIDTH-1:0] s_addr;
  logic [7:0]            s_data;
  logic                  s_rst;
  logic                  s_code_fetch_strobe;
  logic                  s_strobe;
  logic                  s_vpp;
  logic [3:0]            s_mode;
  logic                  s_ea;
  assign {s_addr, s_data, s_rst, s_code_fetch_strobe, s_strobe, s_vpp, s_mode, s_ea} = r.sync2;
  assign mem_rd = mem[s_addr];

  function automatic logic vpp_ok(input logic level, input logic hv);
    vpp_ok = LOW_VOLTAGE ? level : (level && hv); // RULE2
  endfunction

  always_comb begin
    next_r       = r;
    mem_we       = 1'b0;
    mem_clear    = 1'b0;
    next_r.sync1 = {link.address_high, link.address_low, link.data_from_host, link.reset_pin,
                    link.code_fetch_strobe, link.program_strobe,
                    vpp_ok(link.external_access_vpp_pin, link.vpp_high_voltage),
                    link.mode_select_a, link.mode_select_b_enable, link.mode_select_c,
                    link.mode_select_d, external_access_pin_i}; // RULE22
    next_r.sync2 = r.sync1;
    next_r.strobe_prev = s_strobe;
    // ------------------------------------------------------------
    // access level capture while in reset
    // ------------------------------------------------------------
    if (!s_rst) begin
      next_r.ea_latch = s_ea; // RULE19
      next_r.ea_armed = 1'b1;
    end
    next_r.tr_allowed  = !(r.lock[0] && table_read_external_i); // RULE17
    next_r.ext_allowed = !(r.lock == 3'b111) &&
                         !(r.lock[0] && r.ea_armed && (r.ea_latch != s_ea)); // RULE18
    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    case (r.state)
      ST_IDLE: begin
        next_r.ready = 1'b1;
        // erase strobe held low for the full erase time
        if (s_rst && !s_code_fetch_strobe && s_vpp && s_mode == MODE_CHIP_ERASE && !s_strobe) begin
          next_r.erase_count = r.erase_count + 32'd1;
          if (r.erase_count == 32'(ERASE_TIME - 1)) begin
            mem_clear   = 1'b1; // RULE12
            next_r.lock = 3'b000;
          end
        end else begin
          next_r.erase_count = 32'd0;
        end
        // a write starts at the strobe's rising edge
        if (s_strobe && !r.strobe_prev && s_rst && !s_code_fetch_strobe && s_vpp) begin // RULE5
          if (s_mode == MODE_WRITE_CODE && !r.lock[0]) begin // RULE13 RULE17
            next_r.ready     = 1'b0; // RULE8 RULE9
            next_r.pend_addr = s_addr;
            next_r.last_addr = s_addr;
            next_r.last_data = s_data;
            next_r.timer     = 32'd0;
            next_r.state     = ST_WRITE;
          end else if (s_mode[3:2] == 2'b11 && s_mode[1:0] != 2'b00) begin // RULE14
            next_r.ready = 1'b0;
            next_r.timer = 32'd0;
            next_r.pend_addr = {{(ADDR_WIDTH-2){1'b0}}, s_mode[1:0]};
            next_r.state = ST_LOCK;
          end
        end
      end
      ST_WRITE, ST_LOCK: begin
        next_r.ready = 1'b0; // RULE21
        next_r.timer = r.timer + 32'd1;
        if (r.timer == 32'(WRITE_TIME - 1)) begin // RULE9
          if (r.state == ST_WRITE)
            mem_we = 1'b1; // RULE3
          else if (r.pend_addr[1:0] == 2'b11)
            next_r.lock[0] = 1'b1;
          else if (r.pend_addr[1:0] == 2'b10)
            next_r.lock[1] = 1'b1;
          else
            next_r.lock[2] = 1'b1;
          next_r.ready = 1'b1; // RULE7
          next_r.state = ST_IDLE;
        end
      end
      default: next_r.state = ST_IDLE;
    endcase
    // ------------------------------------------------------------
    // read path: verify, signature, polling
    // ------------------------------------------------------------
    next_r.oe_n = 1'b1;
    next_r.dout = 8'h00;
    if (s_rst && !s_code_fetch_strobe && s_strobe && !s_mode[3]) begin
      if (s_mode == MODE_READ_SIG) begin // RULE15 RULE16
        next_r.oe_n = 1'b0;
        if (s_addr == SIG_ADDR_MAKER)
          next_r.dout = SIG_MAKER_CODE;
        else if (s_addr == SIG_ADDR_PART)
          next_r.dout = SIG_PART_CODE;
        else if (s_addr == SIG_ADDR_VPP)
          next_r.dout = LOW_VOLTAGE ? SIG_VPP_LOW : SIG_VPP_HIGH;
        else
          next_r.dout = ERASED_BYTE;
      end else if (s_mode == MODE_READ_CODE && !(r.lock[0] && r.lock[1])) begin // RULE10 RULE11
        next_r.oe_n = 1'b0;
        if (r.state == ST_WRITE && s_addr == r.last_addr)
          next_r.dout = {~r.last_data[7], 7'h00}; // RULE6
        else
          next_r.dout = mem_rd; // RULE7
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      r.state       <= ST_IDLE;
      r.sync1       <= SYNC_IDLE;
      r.sync2       <= SYNC_IDLE;
      r.strobe_prev <= 1'b1;
      r.timer       <= 32'd0;
      r.erase_count <= 32'd0;
      r.last_addr   <= '0;
      r.last_data   <= 8'h00;
      r.pend_addr   <= '0;
      r.lock        <= 3'b000;
      r.ea_latch    <= 1'b0;
      r.ea_armed    <= 1'b0;
      r.dout        <= 8'h00;
      r.oe_n        <= 1'b1;
      r.ready       <= 1'b1;
      r.tr_allowed  <= 1'b1;
      r.ext_allowed <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // array storage; starts blank
  initial begin
    for (int i = 0; i < MEM_DEPTH; i++)
      mem[i] = ERASED_BYTE; // RULE1
  end

  // plain always: the array is also preset at time zero
  always @(posedge clock_i) begin
    if (mem_clear) begin
      for (int i = 0; i < MEM_DEPTH; i++)
        mem[i] <= ERASED_BYTE; // RULE12
    end else if (mem_we) begin
      mem[r.pend_addr] <= r.last_data;
    end
  end

  assign link.data_from_device      = r.dout;
  assign link.data_oe_n             = r.oe_n;
  assign link.ready_busy_port_bit   = r.ready;
  assign table_read_allowed_o       = r.tr_allowed;
  assign external_run_allowed_o     = r.ext_allowed;
  assign external_access_latched_o  = r.ea_latch;
endmodule
`default_nettype wire

/* flash_program_strobe_pkg.sv */
// constants and types shared by both ends of the flash programming link
// assumes a single 200 MHz clock on both ends
package flash_program_strobe_pkg;
  localparam int CLOCK_MHZ          = 200;
  localparam int ADDR_WIDTH         = 12;
  localparam int MEM_DEPTH          = 4096;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [11:0] SIG_ADDR_MAKER = 12'h030;
  localparam logic [11:0] SIG_ADDR_PART  = 12'h031;
  localparam logic [11:0] SIG_ADDR_VPP   = 12'h032;
  localparam logic [7:0] SIG_VPP_HIGH    = 8'hFF;
  localparam logic [7:0] SIG_VPP_LOW     = 8'h05;
  localparam logic [7:0] SIG_MAKER_CODE  = 8'hA5; // arbitrary value
  localparam logic [7:0] SIG_PART_CODE   = 8'h3C; // arbitrary value
  // timing figures
  localparam int WRITE_TYPICAL_US    = 1500;
  localparam int BUSY_DELAY_NS       = 1000;
  localparam int STROBE_MIN_US       = 1;
  localparam int STROBE_MAX_US       = 110;
  localparam int VPP_SETUP_US        = 10;
  localparam int ERASE_STROBE_MS     = 10;
  localparam int WRITE_CYCLES        = WRITE_TYPICAL_US * CLOCK_MHZ;
  localparam int BUSY_DELAY_CYCLES   = (BUSY_DELAY_NS * CLOCK_MHZ) / 1000;
  localparam int STROBE_CYCLES       = STROBE_MIN_US * CLOCK_MHZ + CLOCK_MHZ;
  localparam int VPP_SETUP_CYCLES    = VPP_SETUP_US * CLOCK_MHZ;
  localparam int ERASE_STROBE_CYCLES = ERASE_STROBE_MS * 1000 * CLOCK_MHZ;
  // mode select codes {a,b,c,d}
  localparam logic [3:0] MODE_WRITE_CODE = 4'h7;
  localparam logic [3:0] MODE_READ_CODE  = 4'h3;
  localparam logic [3:0] MODE_CHIP_ERASE = 4'h8;
  localparam logic [3:0] MODE_READ_SIG   = 4'h0;
  localparam logic [3:0] MODE_LOCK_ONE   = 4'hF;
  localparam logic [3:0] MODE_LOCK_TWO   = 4'hE;
  localparam logic [3:0] MODE_LOCK_THREE = 4'hD;
  typedef enum logic [3:0] {
    OP_WRITE = 4'h1,
    OP_READ  = 4'h2,
    OP_ERASE = 4'h4,
    OP_LOCK  = 4'h8
  } host_op_type;
endpackage

/* flash_program_strobe_if.sv */
// pin bundle between the flash device and its programmer
// assumes both ends share clock_i
`timescale 1ns/1ps
`default_nettype none
interface flash_program_strobe_if;
  logic [7:0] address_low;
  logic [3:0] address_high;
  logic [7:0] data_from_host;
  logic [7:0] data_from_device;
  logic       data_oe_n;
  logic       reset_pin;
  logic       code_fetch_strobe;
  logic       program_strobe;
  logic       external_access_vpp_pin;
  logic       vpp_high_voltage;
  logic       mode_select_a;
  logic       mode_select_b_enable;
  logic       mode_select_c;
  logic       mode_select_d;
  logic       ready_busy_port_bit;
  modport device (
    input  address_low, address_high, data_from_host, reset_pin, code_fetch_strobe,
    input  program_strobe, external_access_vpp_pin, vpp_high_voltage,
    input  mode_select_a, mode_select_b_enable, mode_select_c, mode_select_d,
    output data_from_device, data_oe_n, ready_busy_port_bit
  );
  modport host (
    output address_low, address_high, data_from_host, reset_pin, code_fetch_strobe,
    output program_strobe, external_access_vpp_pin, vpp_high_voltage,
    output mode_select_a, mode_select_b_enable, mode_select_c, mode_select_d,
    input  data_from_device, data_oe_n, ready_busy_port_bit
  );
endinterface
`default_nettype wire

/* flash_program_strobe_host.sv */
// programmer end: drives pins for write, read, erase and lock commands
// assumes device answers on the shared interface; two-entry buffer feeds reads out
`timescale 1ns/1ps
`default_nettype none
module flash_program_strobe_host
  import flash_program_strobe_pkg::*;
#(
  parameter int ERASE_TIME  = flash_program_strobe_pkg::ERASE_STROBE_CYCLES,
  parameter int SETUP_TIME  = flash_program_strobe_pkg::VPP_SETUP_CYCLES,
  parameter int STROBE_TIME = flash_program_strobe_pkg::STROBE_CYCLES
)(
  input  wire logic                    clock_i,
  input  wire logic                    resetn_i,
  flash_program_strobe_if.host                   link,
  input  wire logic                    cmd_valid_i,
  input  wire flash_program_strobe_pkg::host_op_type cmd_op_i,
  input  wire logic [flash_program_strobe_pkg::ADDR_WIDTH-1:0] cmd_addr_i,
  input  wire logic [7:0]              cmd_data_i,
  input  wire logic [3:0]              cmd_mode_i,
  output logic                         cmd_ready_o,
  output logic                         rd_valid_o,
  output logic [7:0]                   rd_data_o,
  input  wire logic                    rd_ready_i
);
  import flash_program_strobe_pkg::*;

  if (SETUP_TIME < 1 || STROBE_TIME < 1 || ERASE_TIME < 1) begin : bad_timing
    $error("flash_program_strobe_host: timing parameters too small");
  end

  typedef enum logic [4:0] {
    H_IDLE   = 5'b00001,
    H_SETUP  = 5'b00010,
    H_STROBE = 5'b00100,
    H_WAIT   = 5'b01000,
    H_READ   = 5'b10000
  } host_state_type;

  typedef struct packed {
    host_state_type        state;
    host_op_type           op;
    logic [31:0]           timer;
    logic [1:0]            rb_sync;
    logic [1:0]            oe_sync;
    logic [7:0]            d_sync1;
    logic [7:0]            d_sync2;
    logic [1:0][7:0]       buf_data;
    logic [1:0]            count;
    logic                  wr_ptr;
    logic                  rd_ptr;
    logic [ADDR_WIDTH-1:0] addr;
    logic [7:0]            data;
    logic [3:0]            mode;
    logic                  strobe;
    logic                  vpp;
    logic                  ready;
  } host_reg_type;

  host_reg_type r;
  host_reg_type next_r;
  logic         push;
  logic         pop;

  always_comb begin
    next_r         = r;
    next_r.rb_sync = {r.rb_sync[0], link.ready_busy_port_bit};
    next_r.oe_sync = {r.oe_sync[0], link.data_oe_n};
    next_r.d_sync1 = link.data_from_device;
    next_r.d_sync2 = r.d_sync1;
    next_r.timer   = r.timer + 32'd1;
    push           = 1'b0;
    pop            = (r.count != 2'd0) && rd_ready_i;
    case (r.state)
      H_IDLE: begin
        next_r.ready  = (r.count != 2'd2);
        next_r.strobe = 1'b1;
        next_r.vpp    = 1'b0;
        if (cmd_valid_i && r.ready) begin // RULE4
          next_r.ready = 1'b0;
          next_r.op    = cmd_op_i;
          next_r.addr  = cmd_addr_i;
          next_r.data  = cmd_data_i;
          next_r.timer = 32'd0;
          case (cmd_op_i)
            OP_WRITE: next_r.mode = MODE_WRITE_CODE; // RULE13
            OP_ERASE: next_r.mode = MODE_CHIP_ERASE;
            OP_LOCK:  next_r.mode = {2'b11, cmd_mode_i[1:0]}; // RULE14
            default:  next_r.mode = cmd_mode_i[0] ? MODE_READ_CODE : MODE_READ_SIG; // RULE15
          endcase
          next_r.vpp   = (cmd_op_i != OP_READ);
          next_r.state = (cmd_op_i == OP_READ) ? H_READ : H_SETUP;
        end
      end
      H_SETUP: if (r.timer == 32'(SETUP_TIME - 1)) begin // RULE20
        next_r.strobe = 1'b0;
        next_r.timer  = 32'd0;
        next_r.state  = H_STROBE;
      end
      H_STROBE: if (r.timer == ((r.op == OP_ERASE) ? 32'(ERASE_TIME - 1) : 32'(STROBE_TIME - 1))) begin
        next_r.strobe = 1'b1; // RULE5 RULE12
        next_r.timer  = 32'd0;
        next_r.state  = H_WAIT;
      end
      H_WAIT: if (r.timer > 32'(SETUP_TIME) && r.rb_sync[1]) begin // RULE7
        next_r.vpp   = 1'b0;
        next_r.state = H_IDLE;
      end
      H_READ: if (r.timer == 32'd8) begin
        push         = 1'b1;
        next_r.state = H_IDLE;
      end
      default: next_r.state = H_IDLE;
    endcase
    // ------------------------------------------------------------
    // two-entry read buffer
    // ------------------------------------------------------------
    if (push) begin
      // released data lines read as their pull-ups
      next_r.buf_data[r.wr_ptr] = r.oe_sync[1] ? 8'hFF : r.d_sync2; // RULE10
      next_r.wr_ptr = ~r.wr_ptr;
    end
    if (pop)
      next_r.rd_ptr = ~r.rd_ptr;
    next_r.count = r.count + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      r <= '{state: H_IDLE, op: OP_READ, strobe: 1'b1, default: '0};
    end else begin
      r <= next_r;
    end
  end

  assign link.address_low             = r.addr[7:0];
  assign link.address_high            = r.addr[ADDR_WIDTH-1:8];
  assign link.data_from_host          = r.data;
  assign link.reset_pin               = 1'b1; // RULE13
  assign link.code_fetch_strobe       = 1'b0;
  assign link.program_strobe          = r.strobe;
  assign link.external_access_vpp_pin = 1'b1;
  assign link.vpp_high_voltage        = r.vpp;
  assign {link.mode_select_a, link.mode_select_b_enable, link.mode_select_c, link.mode_select_d} = r.mode;
  assign cmd_ready_o                  = r.ready;
  assign rd_valid_o                   = (r.count != 2'd0);
  assign rd_data_o                    = r.buf_data[r.rd_ptr];
endmodule
`default_nettype wire

/* flash_program_strobe_asserts.sv */
// concurrent checks on the programming link between flash device and programmer
// assumes link signals, clock_i and resetn_i are connected by name in the bench
`timescale 1ns/1ps
`default_nettype none
module flash_program_strobe_asserts #(
  parameter int WRITE_TIME  = 20,
  parameter int STROBE_TIME = 4,
  parameter int ERASE_TIME  = 34
)(
  input wire logic       clock_i,
  input wire logic       resetn_i,
  input wire logic [7:0] address_low,
  input wire logic [3:0] address_high,
  input wire logic [7:0] data_from_host,
  input wire logic       data_oe_n,
  input wire logic       reset_pin,
  input wire logic       code_fetch_strobe,
  input wire logic       program_strobe,
  input wire logic       external_access_vpp_pin,
  input wire logic       vpp_high_voltage,
  input wire logic       mode_select_a,
  input wire logic       mode_select_b_enable,
  input wire logic       mode_select_c,
  input wire logic       mode_select_d,
  input wire logic       ready_busy_port_bit
);
  // ----------------------------------------
  // helper state
  // ----------------------------------------
  logic [3:0]  mode;
  logic        lock_one;
  logic        lock_two;
  logic [31:0] busy_count;
  logic [31:0] low_count;
  logic        read_cond;
  assign mode = {mode_select_a, mode_select_b_enable, mode_select_c, mode_select_d};
  assign read_cond = program_strobe && reset_pin && !code_fetch_strobe && ready_busy_port_bit &&
                     !(lock_one && lock_two) && (mode == 4'h3 || mode == 4'h0);
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      lock_one   <= 1'b0;
      lock_two   <= 1'b0;
      busy_count <= 32'h0;
      low_count  <= 32'h0;
    end else begin
      busy_count <= ready_busy_port_bit ? 32'h0 : busy_count + 32'h1;
      low_count  <= program_strobe ? 32'h0 : low_count + 32'h1;
      lock_one   <= (lock_one || (!program_strobe && mode == 4'hF)) && !(!program_strobe && mode == 4'h8);
      lock_two   <= (lock_two || (!program_strobe && mode == 4'hE)) && !(!program_strobe && mode == 4'h8);
    end
  end
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!resetn_i);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  chk_busy_after_strobe: assert property (
    $rose(program_strobe) && mode == 4'h7 && ready_busy_port_bit && !lock_one && reset_pin && vpp_high_voltage
    |-> ##[1:200] !ready_busy_port_bit) else $error("busy did not follow the write strobe");
  chk_write_duration: assert property (
    $rose(ready_busy_port_bit) && mode == 4'h7 |-> busy_count inside {[WRITE_TIME-2:WRITE_TIME+2]})
    else $error("write busy time out of range");
  chk_strobe_width: assert property (
    $rose(program_strobe) && mode != 4'h8 |-> low_count inside {[STROBE_TIME-1:STROBE_TIME+1]})
    else $error("program strobe width wrong");
  chk_erase_width: assert property (
    $rose(program_strobe) && mode == 4'h8 |-> low_count >= ERASE_TIME) else $error("erase strobe too short");
  chk_read_drives: assert property (
    read_cond [*4] |-> !data_oe_n) else $error("device not driving data in read mode");
  chk_hold_after: assert property (
    $rose(program_strobe) |-> $stable(address_low) && $stable(address_high) && $stable(data_from_host)
    && vpp_high_voltage) else $error("address, data or voltage moved at strobe end");
  chk_program_strobe_levels: assert property (
    !program_strobe |-> reset_pin && !code_fetch_strobe) else $error("control levels wrong during strobe");
  chk_vpp_setup: assert property (
    $fell(program_strobe) |-> $past(vpp_high_voltage, 4) && external_access_vpp_pin)
    else $error("voltage not set up before strobe");
  chk_lock_no_verify: assert property (
    lock_one && lock_two |-> data_oe_n) else $error("verify data driven while locked");
endmodule
`default_nettype wire

/* testbench.sv */
// self-checking bench: programmer end drives device end over the link
// assumes package, interface, both ends and the checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import flash_program_strobe_pkg::*;
  localparam int WT = 20;
  localparam int ET = 30;
  logic        clock_i, resetn_i, cmd_valid_i, rd_ready_i, cmd_ready_o, rd_valid_o;
  logic        table_read_external, ext_access_pin, table_ok, run_ok;
  host_op_type cmd_op_i;
  logic [11:0] cmd_addr_i;
  logic [11:0] addr[3];
  logic [7:0]  cmd_data_i, rd_data_o;
  logic [7:0]  wdat[3];
  logic [3:0]  cmd_mode_i;
  logic [8:0]  notes[$];
  logic [8:0]  note;
  int          rd_mode, failures, total_checks;
  flash_program_strobe_if link();
  flash_program_strobe_device #(.WRITE_TIME(WT), .ERASE_TIME(ET)) flash_program_strobe_device_i (.clock_i(clock_i),
    .resetn_i(resetn_i), .link(link), .table_read_external_i(table_read_external),
    .external_access_pin_i(ext_access_pin), .table_read_allowed_o(table_ok),
    .external_run_allowed_o(run_ok), .external_access_latched_o());
  flash_program_strobe_host #(.ERASE_TIME(ET + 4), .SETUP_TIME(5), .STROBE_TIME(4)) flash_program_strobe_host_i (
    .clock_i(clock_i), .resetn_i(resetn_i), .link(link), .cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i),
    .cmd_addr_i(cmd_addr_i), .cmd_data_i(cmd_data_i), .cmd_mode_i(cmd_mode_i), .cmd_ready_o(cmd_ready_o),
    .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .rd_ready_i(rd_ready_i));
  flash_program_strobe_asserts #(.WRITE_TIME(WT), .STROBE_TIME(4), .ERASE_TIME(ET + 4)) flash_program_strobe_asserts_i (
    .clock_i(clock_i), .resetn_i(resetn_i), .address_low(link.address_low),
    .address_high(link.address_high), .data_from_host(link.data_from_host), .data_oe_n(link.data_oe_n),
    .reset_pin(link.reset_pin), .code_fetch_strobe(link.code_fetch_strobe),
    .program_strobe(link.program_strobe), .external_access_vpp_pin(link.external_access_vpp_pin),
    .vpp_high_voltage(link.vpp_high_voltage), .mode_select_a(link.mode_select_a),
    .mode_select_b_enable(link.mode_select_b_enable), .mode_select_c(link.mode_select_c),
    .mode_select_d(link.mode_select_d), .ready_busy_port_bit(link.ready_busy_port_bit));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while ((cmd_ready_o !== 1'b1 || notes.size() != 0) && n < 2000) begin
      @(negedge clock_i);
      n++;
    end
    if (n >= 2000) check(8'h01, 8'h00);
  endtask
  // expected read byte goes in d; bit 8 of a note marks a byte not compared
  task automatic cmd(input host_op_type op, input logic [11:0] a, input logic [8:0] d, input logic [3:0] m);
    int n;
    n = 0;
    @(negedge clock_i);
    while (cmd_ready_o !== 1'b1 && n < 2000) begin
      @(negedge clock_i);
      n++;
    end
    if (n >= 2000) check(8'h02, 8'h00);
    cmd_valid_i = 1'b1;
    cmd_op_i    = op;
    cmd_addr_i  = a;
    cmd_data_i  = d[7:0];
    cmd_mode_i  = m;
    if (op == OP_READ) notes.push_back(d);
    @(negedge clock_i);
    cmd_valid_i = 1'b0;
  endtask
  task automatic finish_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ----------------------------------------
  // clock, read side stalls, result monitor, watchdog
  // ----------------------------------------
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  // the handshake is judged at the falling edge before the rising edge that takes it
  always @(negedge clock_i) begin
    rd_ready_i = (rd_mode == 0) ? 1'b1 : (rd_mode == 1) ? 1'b0 : 1'($urandom);
    if (resetn_i && rd_valid_o === 1'b1 && rd_ready_i) begin
      if (notes.size() == 0) begin
        check(8'h03, 8'h00);
      end else begin
        note = notes.pop_front();
        if (!note[8]) check(rd_data_o, note[7:0]);
      end
    end
  end
  initial begin
    repeat (20000) @(posedge clock_i);
    failures++;
    $display("[ERR] %0t watchdog expired", $time);
    finish_test();
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    void'($urandom(32'hBA295A92));
    resetn_i = 1'b0;
    cmd_valid_i = 1'b0;
    cmd_op_i = OP_READ;
    cmd_addr_i = 12'h000;
    cmd_data_i = 8'h00;
    cmd_mode_i = 4'h0;
    rd_mode = 0;
    table_read_external = 1'b1;
    ext_access_pin = 1'b1;
    repeat (4) @(negedge clock_i);
    resetn_i = 1'b1;
    for (int i = 0; i < 3; i++) cmd(OP_READ, 12'($urandom), {1'b0, ERASED_BYTE}, 4'h1);
    cmd(OP_READ, SIG_ADDR_MAKER, {1'b0, SIG_MAKER_CODE}, 4'h0);
    cmd(OP_READ, SIG_ADDR_PART, {1'b0, SIG_PART_CODE}, 4'h0);
    cmd(OP_READ, SIG_ADDR_VPP, {1'b0, SIG_VPP_HIGH}, 4'h0);
    wait_idle();
    $display("test blank and signature done");
    addr = '{12'h000, 12'hFFF, 12'h100 + 12'($urandom % 3584)};
    for (int i = 0; i < 3; i++) begin
      wdat[i] = 8'($urandom);
      cmd(OP_WRITE, addr[i], {1'b0, wdat[i]}, 4'h0);
    end
    rd_mode = 1;
    cmd(OP_READ, addr[0], {1'b0, wdat[0]}, 4'h1);
    cmd(OP_READ, addr[1], {1'b0, wdat[1]}, 4'h1);
    repeat (20) @(negedge clock_i);
    check(8'(cmd_ready_o), 8'h00);
    rd_mode = 2;
    cmd(OP_READ, addr[2], {1'b0, wdat[2]}, 4'h1);
    wait_idle();
    rd_mode = 0;
    $display("test write and read back done");
    cmd(OP_ERASE, 12'h000, 9'h000, 4'h0);
    for (int i = 0; i < 3; i++) cmd(OP_READ, addr[i], {1'b0, ERASED_BYTE}, 4'h1);
    wait_idle();
    $display("test erase done");
    cmd(OP_WRITE, 12'h020, 9'h05A, 4'h0);
    cmd(OP_LOCK, 12'h000, 9'h000, 4'h3);
    cmd(OP_WRITE, 12'h021, 9'h000, 4'h0);
    cmd(OP_READ, 12'h021, {1'b0, ERASED_BYTE}, 4'h1);
    cmd(OP_READ, 12'h020, 9'h05A, 4'h1);
    wait_idle();
    check(8'(table_ok), 8'h00);
    check(8'(run_ok), 8'h01);
    cmd(OP_LOCK, 12'h000, 9'h000, 4'h2);
    cmd(OP_READ, 12'h020, 9'h0FF, 4'h1);
    cmd(OP_LOCK, 12'h000, 9'h000, 4'h1);
    wait_idle();
    check(8'(run_ok), 8'h00);
    cmd(OP_ERASE, 12'h000, 9'h000, 4'h0);
    cmd(OP_READ, 12'h020, {1'b0, ERASED_BYTE}, 4'h1);
    wait_idle();
    $display("test lock bits done");
    finish_test();
  end
endmodule
`default_nettype wire
